/* File: core/mrx_mode_regs.sv */
// Overview of operation
// - mode_reg_two holds until reloaded
// - mode loads never touch the array
// - write cas latency from bits 5:3
// - write latency is cas plus additive
// - bit 6 doubles refresh when hot
// - bit 7 always doubles refresh rate
// - bits 10:9 pick write termination
// - write termination during each write burst
// - no write termination in write leveling
// - reserved bits zero, select ignored off
// - bit 2 redirects reads to pattern
// - readout mode redirects every read
// - drive prime lines or all lines
// - eight beat or chop, dll locked
// - column bit 2 selects nibble order when chopped
// - first beat is least significant bit
// - ignore other addresses, a12 on fly
// - pattern alternates zero and one
// - read latency is additive plus cas
// - bank bits select target mode register
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ps
module mrx_mode_regs #(
    parameter int DQ_W = 8,
    parameter int LAT_MAX = 32
) (
    // clock, reset, enable
    input logic mclk,
    input logic reset_n,
    input logic ce,
    // command bus pins from the controller
    input logic link_ck,
    input logic cmd_cs_n,
    input logic cmd_ras_n,
    input logic cmd_cas_n,
    input logic cmd_we_n,
    input logic [mrx_pkg::BA_W-1:0] bank_addr,
    input logic [mrx_pkg::ADDR_W-1:0] addr,
    input logic odt_pin,
    input logic case_hot,
    // local register port
    input logic [1:0] reg_addr,
    input logic [mrx_pkg::REG_W-1:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    output logic [mrx_pkg::REG_W-1:0] reg_rdata,
    // data lines and device controls
    output logic [DQ_W-1:0] dq_out,
    output logic dq_oe_n,
    output logic [1:0] term_state,
    output logic [1:0] write_term_code,
    output logic selfref_double,
    output logic array_read,
    output logic array_write
);
    import mrx_pkg::*;

    // ------------------------------------------------------------
    // parameter checks and constants
    // ------------------------------------------------------------
    localparam int IN_W = 7 + BA_W + ADDR_W;
    localparam logic [DQ_W-1:0] PRIME_MASK =
        (DQ_W == 16) ? DQ_W'(16'h0101) : DQ_W'(16'h0001);
    if (DQ_W != 4 && DQ_W != 8 && DQ_W != 16) begin : g_bad_dq
        $error("DQ_W must be 4, 8 or 16");
    end
    if (LAT_MAX < 22 || LAT_MAX > 32) begin : g_bad_lat
        $error("LAT_MAX must lie in 22..32");
    end

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // latency slot marker for the delay pipes
    function automatic logic [LAT_MAX-1:0] slot(input logic [LAT_W-1:0] lat);
        slot = {{(LAT_MAX-1){1'b0}}, 1'b1} << (lat - 5'd1);
    endfunction : slot

    // additive latency from its code and the cas read latency
    function automatic logic [LAT_W-1:0] add_lat(input logic [1:0] code,
                                                 input logic [3:0] cl);
        case (code)
            AL_CL1: add_lat = {1'b0, cl} - 5'd1;
            AL_CL2: add_lat = {1'b0, cl} - 5'd2;
            default: add_lat = 5'd0;
        endcase
    endfunction : add_lat

    // ------------------------------------------------------------
    // pin synchronisers and link clock edges
    // ------------------------------------------------------------
    logic [IN_W-1:0] s1_r, s2_r;
    logic ck_prev_r;
    wire [IN_W-1:0] pins_raw = {link_ck, cmd_cs_n, cmd_ras_n, cmd_cas_n, cmd_we_n,
                                bank_addr, addr, odt_pin, case_hot};
    wire ck_s = s2_r[IN_W-1];
    wire cs_n_s = s2_r[IN_W-2];
    wire [2:0] cmd_s = s2_r[IN_W-3 -: 3];
    wire [BA_W-1:0] ba_s = s2_r[ADDR_W+2 +: BA_W];
    wire [ADDR_W-1:0] addr_s = s2_r[2 +: ADDR_W];
    wire odt_s = s2_r[1];
    wire hot_s = s2_r[0];
    wire ck_rise = ck_s & ~ck_prev_r;
    wire ck_fall = ~ck_s & ck_prev_r;

    // only the second stage is read by logic
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s1_r <= '0;
            s2_r <= '0;
            ck_prev_r <= 1'b0;
        end else if (ce) begin
            s1_r <= pins_raw;
            s2_r <= s1_r;
            ck_prev_r <= ck_s;
        end
    end

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    logic [13:0] mr2_r, mr3_r;
    logic [REG_W-1:0] ctrl_r;
    wire cmd_sel = ck_rise & ~cs_n_s;
    wire cmd_mrs = cmd_sel & (cmd_s == CMD_MODE_SET);
    wire cmd_rd = cmd_sel & (cmd_s == CMD_READ);
    wire cmd_wr = cmd_sel & (cmd_s == CMD_WRITE);
    // bank bits pick the target; other targets are out of scope
    wire load_mr2 = cmd_mrs & (ba_s == BA_MODE_TWO);
    wire load_mr3 = cmd_mrs & (ba_s == BA_MODE_THREE);

    // ------------------------------------------------------------
    // latencies, burst shape and mode decode
    // ------------------------------------------------------------
    wire [3:0] cas_lat = ctrl_r[CTRL_CL_LSB +: 4];
    wire [1:0] bmode = ctrl_r[CTRL_BM_LSB +: 2];
    wire [LAT_W-1:0] al_w = add_lat(ctrl_r[CTRL_AL_LSB +: 2], cas_lat);
    wire [LAT_W-1:0] cwl_w = CWL_BASE + {2'b00, mr2_r[MR2_CWL_LSB +: 3]};
    wire [LAT_W-1:0] wl_w = cwl_w + al_w;
    wire [LAT_W-1:0] rl_w = al_w + {1'b0, cas_lat};
    // a12 only matters when on-the-fly select is on
    wire chop_w = (bmode == BM_CHOP) | ((bmode == BM_OTF) & ~addr_s[A_CHOP]);
    wire ro_en = mr3_r[MR3_RO_EN];
    // select bits only count while readout is on
    wire ro_pattern = ro_en & (mr3_r[1:0] == RO_SEL_PATTERN);
    wire [1:0] wterm_w = mr2_r[MR2_WTERM_LSB +: 2];
    wire dyn_en = (wterm_w != 2'b00) & ~ctrl_r[CTRL_WLEV];

    // ------------------------------------------------------------
    // mode registers and control register
    // ------------------------------------------------------------
    // contents persist until the next matching load
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mr2_r <= MR_RST;
            mr3_r <= MR_RST;
            ctrl_r <= CTRL_RST;
        end else if (ce) begin
            if (load_mr2) mr2_r <= addr_s;
            if (load_mr3) mr3_r <= addr_s;
            if (reg_wr && reg_addr == REG_CTRL) ctrl_r <= reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // array strobes
    // ------------------------------------------------------------
    logic array_read_r, array_write_r;
    // array reads only with readout off; mode loads never write
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            array_read_r <= 1'b0;
            array_write_r <= 1'b0;
        end else if (ce) begin
            array_read_r <= cmd_rd & ~ro_en;
            array_write_r <= cmd_wr & ~ro_en;
        end
    end

    // ------------------------------------------------------------
    // latency pipes, shifted on each link clock rise
    // ------------------------------------------------------------
    logic [LAT_MAX-1:0] rd_pipe_r, rd_ord_r, rd_chop_r;
    logic [LAT_MAX-1:0] wr_pipe_r, wr_chop_r;
    wire [LAT_MAX-1:0] rd_slot = (cmd_rd & ro_en) ? slot(rl_w) : '0;
    wire [LAT_MAX-1:0] wr_slot = cmd_wr ? slot(wl_w) : '0;
    // a launch sits rl or wl rises after its command
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rd_pipe_r <= '0;
            rd_ord_r <= '0;
            rd_chop_r <= '0;
            wr_pipe_r <= '0;
            wr_chop_r <= '0;
        end else if (ce && ck_rise) begin
            rd_pipe_r <= (rd_pipe_r >> 1) | rd_slot;
            rd_ord_r <= (rd_ord_r >> 1) | (addr_s[A_ORDER] ? rd_slot : '0);
            rd_chop_r <= (rd_chop_r >> 1) | (chop_w ? rd_slot : '0);
            wr_pipe_r <= (wr_pipe_r >> 1) | wr_slot;
            wr_chop_r <= (wr_chop_r >> 1) | (chop_w ? wr_slot : '0);
        end
    end

    // ------------------------------------------------------------
    // readout burst, one beat per link clock edge
    // ------------------------------------------------------------
    logic [2:0] beat_r;
    logic [3:0] left_r;
    logic [DQ_W-1:0] dq_r;
    logic dq_oe_n_r;
    wire rd_start = ck_rise & rd_pipe_r[0] & ctrl_r[CTRL_DLL];
    wire ck_edge = ck_rise | ck_fall;
    // upper nibble only when chopped
    wire [2:0] beat_first = (rd_chop_r[0] & rd_ord_r[0]) ? ORDER_HI : 3'h0;
    wire [3:0] left_first = rd_chop_r[0] ? BEATS_4 : BEATS_8;
    wire [2:0] beat_nxt = rd_start ? beat_first : beat_r + 3'h1;
    wire [3:0] left_nxt = rd_start ? left_first : left_r - 4'h1;
    // beat k carries bit k[0]: first beat lsb, pattern from zero
    wire beat_bit = ro_pattern & beat_nxt[0];
    wire [DQ_W-1:0] dq_nxt = ctrl_r[CTRL_ALL] ? {DQ_W{beat_bit}}
                                              : ({DQ_W{beat_bit}} & PRIME_MASK);
    wire drive_nxt = left_nxt != 4'h0;
    // a back-to-back read restarts at the boundary edge
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            beat_r <= 3'h0;
            left_r <= 4'h0;
            dq_r <= '0;
            dq_oe_n_r <= 1'b1;
        end else if (ce && ck_edge && (rd_start || left_r != 4'h0)) begin
            beat_r <= beat_nxt;
            left_r <= left_nxt;
            dq_r <= drive_nxt ? dq_nxt : '0;
            dq_oe_n_r <= ~drive_nxt;
        end
    end

    // ------------------------------------------------------------
    // write termination window and self refresh rate
    // ------------------------------------------------------------
    logic [2:0] wclk_r;
    logic [1:0] term_r, wcode_r;
    logic sref_r;
    wire wr_start = ck_rise & wr_pipe_r[0];
    wire [2:0] wclk_nxt = wr_start ? (wr_chop_r[0] ? WCLK_4 : WCLK_8)
                                   : ((ck_rise && wclk_r != 3'h0) ? wclk_r - 3'h1 : wclk_r);
    // nominal termination is high impedance when disabled
    wire [1:0] nom_state = (odt_s & ctrl_r[CTRL_NOM]) ? TERM_NOM : TERM_OFF;
    // write termination replaces nominal for the burst
    wire [1:0] term_nxt = (dyn_en && wclk_nxt != 3'h0) ? TERM_WR : nom_state;
    // srt forces double; asr doubles only while hot
    wire sref_nxt = mr2_r[MR2_SRT] | (mr2_r[MR2_ASR] & hot_s);
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wclk_r <= 3'h0;
            term_r <= TERM_OFF;
            wcode_r <= 2'h0;
            sref_r <= 1'b0;
        end else if (ce) begin
            wclk_r <= wclk_nxt;
            term_r <= term_nxt;
            wcode_r <= wterm_w;
            sref_r <= sref_nxt;
        end
    end

    // ------------------------------------------------------------
    // register read port, data one cycle after the strobe
    // ------------------------------------------------------------
    logic [REG_W-1:0] rdata_r;
    wire [REG_W-1:0] stat_w = {2'b00, rl_w, wl_w, term_r == TERM_WR, ~dq_oe_n_r,
                               ro_en, sref_r};
    wire [REG_W-1:0] rsel_w = (reg_addr == REG_CTRL) ? ctrl_r :
                              (reg_addr == REG_MR2) ? {2'b00, mr2_r} :
                              (reg_addr == REG_MR3) ? {2'b00, mr3_r} : stat_w;
    // data stands only in the cycle after the strobe
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r <= '0;
        end else if (ce) begin
            rdata_r <= reg_rd ? rsel_w : '0;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata = rdata_r;
    assign dq_out = dq_r;
    assign dq_oe_n = dq_oe_n_r;
    assign term_state = term_r;
    assign write_term_code = wcode_r;
    assign selfref_double = sref_r;
    assign array_read = array_read_r;
    assign array_write = array_write_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence s_launch;
        ce && rd_start;
    endsequence
    sequence s_first_beat;
        !dq_oe_n_r && !dq_r[0];
    endsequence

    AST_MR2_LOAD: assert property (ce && load_mr2 |=> mr2_r == $past(addr_s))
        else $error("mode_reg_two not loaded from address");
    AST_MR2_HOLD: assert property (!load_mr2 |=> $stable(mr2_r))
        else $error("mode_reg_two changed without a load");
    AST_SREF_FORCED: assert property (ce && mr2_r[MR2_SRT] |=> sref_r)
        else $error("forced extended refresh not doubled");
    AST_SREF_NORMAL: assert property (ce && !mr2_r[MR2_SRT] && !mr2_r[MR2_ASR]
                                      |=> !sref_r)
        else $error("refresh doubled while both modes off");
    AST_NO_ARRAY_READ: assert property (ce && cmd_rd && ro_en |=> !array_read_r)
        else $error("array read during readout mode");
    AST_FIRST_BEAT: assert property (s_launch |=> s_first_beat)
        else $error("readout did not start with a zero beat");
    AST_PRIME_ONLY: assert property (!ctrl_r[CTRL_ALL] && $stable(ctrl_r)
                                     |-> (dq_r & ~PRIME_MASK) == '0)
        else $error("non prime data line driven high");
    AST_NO_WT_LEVEL: assert property (ctrl_r[CTRL_WLEV] && $past(ctrl_r[CTRL_WLEV])
                                      |-> term_r != TERM_WR)
        else $error("write termination during write leveling");
    AST_ZERO_CODE: assert property (wterm_w == 2'b00 && $past(wterm_w) == 2'b00
                                    |-> term_r != TERM_WR)
        else $error("write termination with zero code");

endmodule : mrx_mode_regs

/* File: core/mrx_pkg.sv */
package mrx_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int BA_W = 3;
    localparam int ADDR_W = 14;
    localparam int REG_W = 16;
    localparam int LAT_W = 5;

    // ------------------------------------------------------------
    // command bus encodings
    // ------------------------------------------------------------
    // bank address carried with a mode register set
    localparam logic [2:0] BA_MODE_TWO = 3'h2;
    localparam logic [2:0] BA_MODE_THREE = 3'h3;
    // {ras_n, cas_n, we_n} with chip select low
    localparam logic [2:0] CMD_MODE_SET = 3'h0;
    localparam logic [2:0] CMD_READ = 3'h5;
    localparam logic [2:0] CMD_WRITE = 3'h4;
    // address bits used by a read
    localparam int A_ORDER = 2;
    localparam int A_CHOP = 12;

    // ------------------------------------------------------------
    // mode_reg_two and mode_reg_three fields
    // ------------------------------------------------------------
    localparam int MR2_CWL_LSB = 3;
    localparam int MR2_ASR = 6;
    localparam int MR2_SRT = 7;
    localparam int MR2_WTERM_LSB = 9;
    localparam logic [4:0] CWL_BASE = 5'h05;
    localparam int MR3_RO_EN = 2;
    localparam logic [1:0] RO_SEL_PATTERN = 2'h0;
    localparam logic [13:0] MR_RST = 14'h0000;

    // ------------------------------------------------------------
    // local register port
    // ------------------------------------------------------------
    localparam logic [1:0] REG_CTRL = 2'h0;
    localparam logic [1:0] REG_MR2 = 2'h1;
    localparam logic [1:0] REG_MR3 = 2'h2;
    localparam logic [1:0] REG_STAT = 2'h3;
    localparam int CTRL_CL_LSB = 0;
    localparam int CTRL_AL_LSB = 4;
    localparam int CTRL_BM_LSB = 6;
    localparam int CTRL_WLEV = 8;
    localparam int CTRL_NOM = 9;
    localparam int CTRL_ALL = 10;
    localparam int CTRL_DLL = 11;
    localparam logic [15:0] CTRL_RST = 16'h0805;
    // burst mode and additive latency codes
    localparam logic [1:0] BM_FIXED8 = 2'h0;
    localparam logic [1:0] BM_OTF = 2'h1;
    localparam logic [1:0] BM_CHOP = 2'h2;
    localparam logic [1:0] AL_CL1 = 2'h1;
    localparam logic [1:0] AL_CL2 = 2'h2;

    // ------------------------------------------------------------
    // termination states and burst sizes
    // ------------------------------------------------------------
    localparam logic [1:0] TERM_OFF = 2'h0;
    localparam logic [1:0] TERM_NOM = 2'h1;
    localparam logic [1:0] TERM_WR = 2'h2;
    localparam logic [3:0] BEATS_8 = 4'h8;
    localparam logic [3:0] BEATS_4 = 4'h4;
    localparam logic [2:0] WCLK_8 = 3'h4;
    localparam logic [2:0] WCLK_4 = 3'h2;
    localparam logic [2:0] ORDER_HI = 3'h4;

endpackage : mrx_pkg

/* File: bench/mrx_ctrl_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// memory controller model driving the command bus
// ------------------------------------------------------------
module mrx_ctrl_model (
    // link clock and command pins
    output logic link_ck,
    output logic cmd_cs_n,
    output logic cmd_ras_n,
    output logic cmd_cas_n,
    output logic cmd_we_n,
    output logic [2:0] bank_addr,
    output logic [13:0] addr
);
    import mrx_pkg::*;

    // free running link clock, phase unrelated to mclk
    initial begin
        link_ck = 1'b0;
        cmd_cs_n = 1'b1;
        {cmd_ras_n, cmd_cas_n, cmd_we_n} = 3'h7;
        bank_addr = 3'h0;
        addr = 14'h0000;
        #137;
        forever #200 link_ck = ~link_ck;
    end

    // one command per call, launched after a falling link edge
    task issue(input logic [2:0] cmd, input logic [2:0] ba, input logic [13:0] a);
        logic [13:0] v;
        v = a;
        if (cmd == CMD_MODE_SET && ba == BA_MODE_TWO) begin
            v = v & 14'h06F8;
            v[MR2_ASR] = v[MR2_ASR] & ~v[MR2_SRT];
        end
        if (cmd == CMD_MODE_SET && ba == BA_MODE_THREE) v = v & 14'h0007;
        if (cmd == CMD_READ) v[1:0] = 2'h0;
        @(negedge link_ck);
        cmd_cs_n <= 1'b0;
        {cmd_ras_n, cmd_cas_n, cmd_we_n} <= cmd;
        bank_addr <= ba;
        addr <= v;
        @(posedge link_ck);
        @(negedge link_ck);
        // deselected pins show the inverse so stale values never look valid
        cmd_cs_n <= 1'b1;
        {cmd_ras_n, cmd_cas_n, cmd_we_n} <= ~cmd;
        bank_addr <= ~ba;
        addr <= ~v;
        // mode delays are kept for every command, which also spaces reads
        repeat (4) @(posedge link_ck);
    endtask : issue
endmodule : mrx_ctrl_model

/* File: bench/mrx_mode_regs_tb.sv */
`timescale 1ns/1ps
module mrx_mode_regs_tb;
    import mrx_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic mclk = 1'b0, reset_n = 1'b0, odt_pin = 1'b0, case_hot = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, all_mode = 1'b0, prev_bit, first_bit;
    logic [1:0] reg_addr = 2'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, rd_val;
    logic link_ck, cmd_cs_n, cmd_ras_n, cmd_cas_n, cmd_we_n;
    logic [2:0] bank_addr;
    logic [13:0] addr;
    logic [7:0] dq_out;
    logic dq_oe_n, selfref_double, array_read, array_write;
    logic [1:0] term_state, write_term_code;
    int errors = 0, check_count = 0;
    int oe_cyc, flips, line_bad, aw_cnt, ar_cnt, wr_cyc, lat_cnt, lat_seen;

    always #25 mclk = ~mclk;

    mrx_ctrl_model ctl (.link_ck(link_ck), .cmd_cs_n(cmd_cs_n), .cmd_ras_n(cmd_ras_n),
        .cmd_cas_n(cmd_cas_n), .cmd_we_n(cmd_we_n), .bank_addr(bank_addr), .addr(addr));

    mrx_mode_regs dut (.mclk(mclk), .reset_n(reset_n), .ce(1'b1), .link_ck(link_ck),
        .cmd_cs_n(cmd_cs_n), .cmd_ras_n(cmd_ras_n), .cmd_cas_n(cmd_cas_n),
        .cmd_we_n(cmd_we_n), .bank_addr(bank_addr), .addr(addr), .odt_pin(odt_pin),
        .case_hot(case_hot), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .term_state(term_state), .write_term_code(write_term_code),
        .selfref_double(selfref_double), .array_read(array_read), .array_write(array_write));

    // ------------------------------------------------------------
    // output monitor
    // ------------------------------------------------------------
    // latency counts from the link rise that carries a command
    always @(posedge link_ck) if (cmd_cs_n === 1'b0) lat_cnt = 0;

    always @(posedge mclk) begin
        lat_cnt++;
        if (dq_oe_n === 1'b0) begin
            if (oe_cyc == 0) begin
                first_bit = dq_out[0];
                lat_seen = lat_cnt;
            end else if (dq_out[0] !== prev_bit) flips++;
            prev_bit = dq_out[0];
            oe_cyc++;
            if (dq_out !== (all_mode ? {8{dq_out[0]}} : {7'h00, dq_out[0]})) line_bad++;
        end
        if (array_write === 1'b1) aw_cnt++;
        if (array_read === 1'b1) ar_cnt++;
        if (term_state === TERM_WR) wr_cyc++;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task clear_mon();
        @(negedge mclk);
        {oe_cyc, flips, line_bad, aw_cnt, ar_cnt, wr_cyc, lat_seen} = '0;
    endtask : clear_mon

    task reg_write(input logic [1:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // read data stand only in the cycle after the strobe
    task reg_read(input logic [1:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask : reg_read

    task tally_and_finish();
        $display("comparisons %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------
    // tables and watchdog
    // ------------------------------------------------------------
    // ctrl, mode_reg_two, odt, write termination expected, end state
    logic [15:0] t_ctrl [4] = '{16'h0A05, 16'h0805, 16'h0B05, 16'h0A05};
    logic [13:0] t_mr2 [4] = '{14'h0200, 14'h0200, 14'h0400, 14'h0000};
    logic [1:0] t_end [4] = '{TERM_NOM, TERM_OFF, TERM_NOM, TERM_NOM};
    // ctrl, read address, bank, beats
    logic [15:0] r_ctrl [4] = '{16'h0805, 16'h0845, 16'h0C85, 16'h0005};
    logic [13:0] r_addr [4] = '{14'h1000, 14'h0004, 14'h2BF8, 14'h1000};
    int r_beats [4] = '{8, 4, 4, 0};

    initial begin
        #400_000;
        errors++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (6) @(posedge mclk);
        clear_mon();
        reg_read(REG_CTRL); check(rd_val, 16'h0805);
        reg_read(REG_MR2); check(rd_val, 16'h0000);
        reg_read(REG_STAT); check(rd_val, 16'h0A50);
        // cwl code 3, auto refresh, termination code 1
        ctl.issue(CMD_MODE_SET, BA_MODE_TWO, 14'h0258);
        reg_read(REG_MR2); check(rd_val, 16'h0258);
        check(16'(write_term_code), 16'h1);
        check(16'(selfref_double), 16'h0);
        // running hot only once auto refresh is enabled
        @(posedge mclk) case_hot <= 1'b1;
        repeat (6) @(posedge mclk);
        check(16'(selfref_double), 16'h1);
        reg_write(REG_CTRL, 16'h0815);
        reg_read(REG_STAT); check(rd_val, 16'h12C1);
        // additive latency of cas minus two
        reg_write(REG_CTRL, 16'h0825);
        reg_read(REG_STAT); check(rd_val, 16'h10B1);
        reg_write(REG_CTRL, 16'h0805);
        // other bank targets leave both registers alone
        ctl.issue(CMD_MODE_SET, 3'h0, 14'h1234);
        reg_read(REG_MR2); check(rd_val, 16'h0258);
        reg_read(REG_MR3); check(rd_val, 16'h0000);
        check(16'(aw_cnt + ar_cnt), 16'h0);
        @(posedge mclk) case_hot <= 1'b0;
        ctl.issue(CMD_MODE_SET, BA_MODE_TWO, 14'h0080);
        repeat (6) @(posedge mclk);
        check(16'(selfref_double), 16'h1);
        ctl.issue(CMD_MODE_SET, BA_MODE_TWO, 14'h0040);
        repeat (6) @(posedge mclk);
        check(16'(selfref_double), 16'h0);
        // write termination cases
        for (int i = 0; i < 4; i++) begin
            reg_write(REG_CTRL, t_ctrl[i]);
            ctl.issue(CMD_MODE_SET, BA_MODE_TWO, t_mr2[i]);
            @(posedge mclk) odt_pin <= (i != 1);
            clear_mon();
            ctl.issue(CMD_WRITE, 3'h0, 14'h0000);
            repeat (48) @(posedge mclk);
            check(16'(wr_cyc > 0), 16'(i < 2));
            check(16'(term_state), 16'(t_end[i]));
            check(16'(aw_cnt), 16'h1);
        end
        odt_pin <= 1'b0;
        reg_write(REG_CTRL, 16'h0805);
        // select bits alone do not redirect reads
        ctl.issue(CMD_MODE_SET, BA_MODE_THREE, 14'h0001);
        clear_mon();
        ctl.issue(CMD_READ, 3'h0, 14'h0000);
        repeat (48) @(posedge mclk);
        check(16'(ar_cnt), 16'h1);
        check(16'(oe_cyc), 16'h0);
        ctl.issue(CMD_MODE_SET, BA_MODE_THREE, 14'h0004);
        for (int i = 0; i < 4; i++) begin
            reg_write(REG_CTRL, r_ctrl[i]);
            all_mode = r_ctrl[i][CTRL_ALL];
            clear_mon();
            ctl.issue(CMD_READ, 3'h7, r_addr[i]);
            repeat (48) @(posedge mclk);
            check(16'(ar_cnt), 16'h0);
            check(16'(oe_cyc > 0), 16'(r_beats[i] > 0));
            if (r_beats[i] > 0) begin
                check(16'(first_bit), 16'h0);
                check(16'(flips), 16'(r_beats[i] - 1));
                check(16'(line_bad), 16'h0);
                check(16'(lat_seen >= 41 && lat_seen <= 46), 16'h1);
            end
        end
        ctl.issue(CMD_MODE_SET, BA_MODE_THREE, 14'h0000);
        reg_read(REG_MR3); check(rd_val, 16'h0000);
        tally_and_finish();
    end
endmodule : mrx_mode_regs_tb
